// *** rtl/osf_supervisor.sv ***
// oscillator supervisor with pll fallback and cpu clock source selection
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module osf_supervisor
   import osf_pkg::*;
#(
   parameter int MISS_LIMIT = OSF_MISS_LIMIT,
   parameter int PLL_DIV    = OSF_PLL_DIV
) (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        OSC_CLK_I,
   input  wire logic        RD_STRAP_I,
   input  wire logic [3:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [3:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   output logic             CPU_CLK_EN_O,
   output logic             FALLBACK_O,
   output logic             PLL_ACTIVE_O,
   output logic             IRQ_O
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic            osc_s1, osc_s2, osc_s3, rd_s1, rd_s2;
   logic            osc_edge, osc_half;
   logic [9:0]      ctrl;
   logic            sup_disable, sdd_pre, sdd_plloff;
   osf_mode_t       mode;
   osf_src_t        src;
   logic            fallback, pll_run, pll_tick, pll_half;
   logic [7:0]      pll_cnt;
   logic [7:0]      miss_cnt;
   logic            miss_det;
   logic [5:0]      sdd_cnt, sdd_target;
   logic            sdd_tick, next_cpu_en;
   logic [0:0]      irq_stat, irq_mask, irq_set, irq_clr;
   logic [3:0]      aw_addr;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   logic            aw_held, w_held, do_write;
   logic [31:0]     rd_word;
   logic            rd_hit, wr_hit;

   // decode of the register map, used by both read and write paths
   function automatic logic addr_hit(input logic [3:0] a);
      return (a == OSF_ADDR_CTRL) || (a == OSF_ADDR_STAT) ||
             (a == OSF_ADDR_IRQ_STAT) || (a == OSF_ADDR_IRQ_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage two is read downstream, stage three only for the oscillator edge
   always_ff @(posedge CORE_CLK_I) begin
      osc_s1 <= OSC_CLK_I;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      rd_s1  <= RD_STRAP_I;
      rd_s2  <= rd_s1;
   end
   assign osc_edge = osc_s2 & ~osc_s3;

   ////////////////////////////////////////////////////////////////////////////
   // control register; bit0 follows the inverted strap while reset is held, byte lanes on write
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         ctrl <= {OSF_CTRL_RESET[9:1], ~rd_s2};
      end else if (do_write && aw_addr == OSF_ADDR_CTRL) begin
         if (w_strb[0]) begin
            ctrl[7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            ctrl[9:8] <= w_data[9:8];
         end
      end
   end
   assign sup_disable = ctrl[OSF_CTRL_DIS_BIT];
   assign mode        = osf_mode_t'(ctrl[OSF_CTRL_MODE_HI:OSF_CTRL_MODE_LO]);
   assign sdd_pre     = ctrl[OSF_CTRL_SDD_PRE];
   assign sdd_plloff  = ctrl[OSF_CTRL_SDD_PLLOFF];

   ////////////////////////////////////////////////////////////////////////////
   // pll base clock as an enable from the core clock, never from the crystal
   // the pll must run in fallback even if software asked it off
   assign fallback = (src == OSF_SRC_PLL);
   assign pll_run  = fallback ||
                     (!sup_disable && !(mode == OSF_MODE_SLOWDOWN && sdd_plloff));
   assign pll_tick = pll_run && (pll_cnt == 8'(PLL_DIV - 1));
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || !pll_run) begin
         pll_cnt <= 8'h00;
      end else if (pll_tick) begin
         pll_cnt <= 8'h00;
      end else begin
         pll_cnt <= pll_cnt + 8'h01;
      end
   end
   // pll halving phase for prescaler fallback
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || !pll_run) begin
         pll_half <= 1'b0;
      end else if (pll_tick) begin
         pll_half <= ~pll_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // missing-edge counter in reference periods, cleared by any rising oscillator edge
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || !pll_run || osc_edge) begin
         miss_cnt <= 8'h00;
      end else if (pll_tick && miss_cnt != 8'(MISS_LIMIT)) begin
         miss_cnt <= miss_cnt + 8'h01;
      end
   end
   assign miss_det = pll_tick && !osc_edge && !sup_disable && !fallback &&
                     (miss_cnt == 8'(MISS_LIMIT - 1));
   ////////////////////////////////////////////////////////////////////////////
   // source selection; only a hardware reset returns to the oscillator
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         src <= OSF_SRC_OSC;
      end else begin
         case (src)
            OSF_SRC_OSC: begin
               if (miss_det) begin
                  src <= OSF_SRC_PLL;
               end
            end
            OSF_SRC_PLL: src <= OSF_SRC_PLL;
            default:     src <= OSF_SRC_OSC;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // oscillator prescaler phase and slow-down divider
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         osc_half <= 1'b0;
      end else if (osc_edge) begin
         osc_half <= ~osc_half;
      end
   end
   // factor 1..32, doubled when prescaling in slow-down
   assign sdd_target = sdd_pre ? 6'({1'b0, ctrl[OSF_CTRL_SDD_HI:OSF_CTRL_SDD_LO]} * 2 + 1)
                               : {1'b0, ctrl[OSF_CTRL_SDD_HI:OSF_CTRL_SDD_LO]};
   assign sdd_tick   = osc_edge && (sdd_cnt >= sdd_target);
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || mode != OSF_MODE_SLOWDOWN) begin
         sdd_cnt <= 6'h00;
      end else if (sdd_tick) begin
         sdd_cnt <= 6'h00;
      end else if (osc_edge) begin
         sdd_cnt <= sdd_cnt + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // cpu clock enable; whole pulses only, so a switch never makes a runt
   always_comb begin
      next_cpu_en = 1'b0;
      if (fallback) begin
         case (mode)
            OSF_MODE_PRESCALE: next_cpu_en = pll_tick & pll_half;
            default:           next_cpu_en = pll_tick;
         endcase
      end else begin
         case (mode)
            OSF_MODE_DIRECT:   next_cpu_en = osc_edge;
            OSF_MODE_PRESCALE: next_cpu_en = osc_edge & osc_half;
            OSF_MODE_SLOWDOWN: next_cpu_en = sdd_tick;
            default:           next_cpu_en = osc_edge;
         endcase
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         CPU_CLK_EN_O <= 1'b0;
         FALLBACK_O   <= 1'b0;
         PLL_ACTIVE_O <= 1'b0;
      end else begin
         CPU_CLK_EN_O <= next_cpu_en;
         FALLBACK_O   <= fallback;
         PLL_ACTIVE_O <= pll_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear; a set in the same cycle wins
   assign irq_set = miss_det;
   assign irq_clr = (do_write && aw_addr == OSF_ADDR_IRQ_STAT && w_strb[0]) ?
                    w_data[0:0] : 1'h0;
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         irq_stat <= OSF_IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         irq_mask <= OSF_IRQ_RESET;
      end else if (do_write && aw_addr == OSF_ADDR_IRQ_MASK && w_strb[0]) begin
         irq_mask <= w_data[0:0];
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write: address and data taken in either order
   assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
   assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
   assign do_write        = aw_held && w_held && !S_AXI_BVALID_O;
   assign wr_hit          = addr_hit(aw_addr);
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 4'h0;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end
   // write response one cycle after both halves are held
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= OSF_RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID_O <= 1'b1;
         S_AXI_BRESP_O  <= wr_hit ? OSF_RESP_OKAY : OSF_RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
         S_AXI_BVALID_O <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read; unmapped addresses read zero with slverr
   assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
   assign rd_hit          = addr_hit(S_AXI_ARADDR_I);
   always_comb begin
      rd_word = 32'h00000000;
      case (S_AXI_ARADDR_I)
         OSF_ADDR_CTRL:     rd_word[9:0] = ctrl;
         OSF_ADDR_STAT: begin
            rd_word[OSF_STAT_FALLBACK] = fallback;
            rd_word[OSF_STAT_PLL_RUN]  = pll_run;
            rd_word[OSF_STAT_DISABLE]  = sup_disable;
         end
         OSF_ADDR_IRQ_STAT: rd_word[0:0] = irq_stat;
         OSF_ADDR_IRQ_MASK: rd_word[0:0] = irq_mask;
         default:           rd_word = 32'h00000000;
      endcase
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O  <= 32'h00000000;
         S_AXI_RRESP_O  <= OSF_RESP_OKAY;
      end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O  <= rd_word;
         S_AXI_RRESP_O  <= rd_hit ? OSF_RESP_OKAY : OSF_RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);
   property p_edge_clears_miss;
      osc_edge |=> (miss_cnt == 8'h00);
   endproperty
   a_edge_clears_miss: assert property (p_edge_clears_miss)
      else $error("oscillator edge did not clear miss counter");
   property p_fall_raises_irq;
      $rose(fallback) |-> irq_stat[OSF_IRQ_OSC_MISS] && $past(pll_tick);
   endproperty
   a_fall_raises_irq: assert property (p_fall_raises_irq)
      else $error("fallback without interrupt status");
   property p_direct_pll;
      fallback && mode == OSF_MODE_DIRECT && pll_tick |=> CPU_CLK_EN_O;
   endproperty
   a_direct_pll: assert property (p_direct_pll)
      else $error("direct fallback missed a pll pulse");
   property p_prescale_pll;
      fallback && mode == OSF_MODE_PRESCALE && pll_tick |=> CPU_CLK_EN_O == $past(pll_half);
   endproperty
   a_prescale_pll: assert property (p_prescale_pll)
      else $error("prescaler fallback not halving");
   property p_fallback_holds;
      fallback |=> fallback [*4];
   endproperty
   a_fallback_holds: assert property (p_fallback_holds)
      else $error("fallback released without reset");
   property p_pll_idle;
      sup_disable && !fallback |-> !pll_tick ##1 (pll_cnt == 8'h00);
   endproperty
   a_pll_idle: assert property (p_pll_idle)
      else $error("pll running while supervision disabled");
   property p_no_irq_disabled;
      sup_disable && !fallback |=> !fallback && !$rose(irq_stat[OSF_IRQ_OSC_MISS]);
   endproperty
   a_no_irq_disabled: assert property (p_no_irq_disabled)
      else $error("interrupt raised while supervision disabled");
   property p_strap_load;
      @(posedge CORE_CLK_I) disable iff (1'b0)
         $fell(RESET_I) |-> sup_disable == !$past(rd_s2);
   endproperty
   a_strap_load: assert property (p_strap_load)
      else $error("disable bit not loaded from inverted strap");
   property p_sdd_on_edge;
      !fallback && mode == OSF_MODE_SLOWDOWN && CPU_CLK_EN_O |-> $past(osc_edge);
   endproperty
   a_sdd_on_edge: assert property (p_sdd_on_edge)
      else $error("slow-down pulse without oscillator edge");
   property p_miss_limit;
      pll_tick && !osc_edge && !sup_disable && !fallback &&
      miss_cnt == 8'(MISS_LIMIT - 1) |=> fallback ##1 CPU_CLK_EN_O == 1'b0;
   endproperty
   a_miss_limit: assert property (p_miss_limit)
      else $error("missing oscillator not detected at limit");
endmodule // osf_supervisor
`default_nettype wire

// *** rtl/osf_pkg.sv ***
// package for the oscillator supervisor with clock fallback
`default_nettype none
package osf_pkg;
   // register byte offsets
   localparam logic [3:0] OSF_ADDR_CTRL     = 4'h0;
   localparam logic [3:0] OSF_ADDR_STAT     = 4'h4;
   localparam logic [3:0] OSF_ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] OSF_ADDR_IRQ_MASK = 4'hc;
   // control register layout
   localparam int OSF_CTRL_W          = 10;
   localparam int OSF_CTRL_DIS_BIT    = 0;
   localparam int OSF_CTRL_MODE_LO    = 1;
   localparam int OSF_CTRL_MODE_HI    = 2;
   localparam int OSF_CTRL_SDD_LO     = 3;
   localparam int OSF_CTRL_SDD_HI     = 7;
   localparam int OSF_CTRL_SDD_PRE    = 8;
   localparam int OSF_CTRL_SDD_PLLOFF = 9;
   localparam logic [9:0] OSF_CTRL_RESET = 10'h000;
   // status register layout
   localparam int OSF_STAT_FALLBACK = 0;
   localparam int OSF_STAT_PLL_RUN  = 1;
   localparam int OSF_STAT_DISABLE  = 2;
   // interrupt layout
   localparam int OSF_IRQ_W        = 1;
   localparam int OSF_IRQ_OSC_MISS = 0;
   localparam logic [0:0] OSF_IRQ_RESET = 1'h0;
   // axi responses
   localparam logic [1:0] OSF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] OSF_RESP_SLVERR = 2'h2;
   // timing
   localparam int OSF_CORE_FREQ_KHZ = 100000;
   localparam int OSF_PLL_BASE_KHZ  = 4000;
   localparam int OSF_PLL_DIV       = OSF_CORE_FREQ_KHZ / OSF_PLL_BASE_KHZ;
   localparam int OSF_MISS_LIMIT    = 4;
   // cpu clock modes
   typedef enum logic [1:0] {
      OSF_MODE_DIRECT   = 2'b00,
      OSF_MODE_PRESCALE = 2'b01,
      OSF_MODE_SLOWDOWN = 2'b10
   } osf_mode_t;
   // cpu clock source
   typedef enum logic {
      OSF_SRC_OSC = 1'b0,
      OSF_SRC_PLL = 1'b1
   } osf_src_t;
endpackage : osf_pkg
`default_nettype wire

// *** bench/osf_osc_model.sv ***
// far-side model: oscillator pin source and read-strobe strap driver
`default_nettype none
module osf_osc_model #(
   parameter int HALF_NS = 100
) (
   input  wire logic run_i,
   input  wire logic strap_high_i,
   output logic      osc_clk_o,
   output logic      rd_strap_o
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // free-running source, unrelated to the core clock; a dead crystal sits low
   initial begin
      osc_clk_o = 1'b0;
      forever begin
         #(HALF_NS);
         osc_clk_o = run_i ? ~osc_clk_o : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strap is held steady across the end of reset by the bench
   assign rd_strap_o = strap_high_i;
endmodule // osf_osc_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the oscillator supervisor
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import osf_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        osc_run = 1'b1;
   logic        strap_high = 1'b1;
   logic [3:0]  awaddr = 4'h0;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [3:0]  araddr = 4'h0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        cnt_clr = 1'b0;
   logic [15:0] pulses = 16'h0;
   int          miscompares = 0;
   int          check_count = 0;
   wire         osc, strap, awready, wready, bvalid, arready, rvalid;
   wire         cpu_en, fallback, pll_on, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   logic [31:0] d;
   logic [1:0]  r;
   logic [9:0]  ctrl_tab [5:0] = '{10'h006, 10'h0fc, 10'h124, 10'h024, 10'h002, 10'h000};
   logic [15:0] exp_tab  [5:0] = '{16'h64, 16'h3, 16'ha, 16'h14, 16'h32, 16'h64};

   always #5 clk = ~clk;

   osf_osc_model #(.HALF_NS(100)) osc_m (.run_i(osc_run), .strap_high_i(strap_high),
      .osc_clk_o(osc), .rd_strap_o(strap));

   osf_supervisor uut (.CORE_CLK_I(clk), .RESET_I(rst), .OSC_CLK_I(osc), .RD_STRAP_I(strap),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .CPU_CLK_EN_O(cpu_en),
      .FALLBACK_O(fallback), .PLL_ACTIVE_O(pll_on), .IRQ_O(irq));

   ////////////////////////////////////////////////////////////////////////////
   // cpu tick counter over a measuring window
   always @(posedge clk) begin
      if (cnt_clr) begin
         pulses <= 16'h0;
      end else if (cpu_en === 1'b1) begin
         pulses <= pulses + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparison, verdict and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] exp_r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // each half released only on the edge that took it
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, exp_r});
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic rd_exp(input logic [3:0] a, input logic [31:0] exp);
      axi_rd(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, OSF_RESP_OKAY});
   endtask

   // tick count over 2000 cycles may be off by one through phase
   task automatic measure(input logic [15:0] exp);
      repeat (100) @(posedge clk);
      cnt_clr <= 1'b1;
      @(posedge clk);
      cnt_clr <= 1'b0;
      repeat (2000) @(posedge clk);
      check({31'h0, (pulses + 16'h1 >= exp) && (pulses <= exp + 16'h1)}, 32'h1);
   endtask

   task automatic do_reset(input logic s);
      strap_high <= s;
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole run needs about 24000 cycles
   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      do_reset(1'b1);
      rd_exp(OSF_ADDR_CTRL, 32'h0);
      rd_exp(OSF_ADDR_STAT, 32'h2);
      check({31'h0, pll_on}, 32'h1);
      axi_rd(4'h2, d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, OSF_RESP_SLVERR});
      axi_wr(4'h2, 32'h1, OSF_RESP_SLVERR);
      rd_exp(OSF_ADDR_CTRL, 32'h0);
      // direct, prescaler, slowdown by 5, 10 and 32, then the spare mode code as direct
      for (int i = 0; i < 6; i++) begin
         axi_wr(OSF_ADDR_CTRL, {22'h0, ctrl_tab[i]}, OSF_RESP_OKAY);
         measure(exp_tab[i]);
      end
      // slowdown with the pll parked: reference stops, supervision idles
      axi_wr(OSF_ADDR_CTRL, 32'h204, OSF_RESP_OKAY);
      rd_exp(OSF_ADDR_STAT, 32'h0);
      check({31'h0, pll_on}, 32'h0);
      axi_wr(OSF_ADDR_CTRL, 32'h0, OSF_RESP_OKAY);
      axi_wr(OSF_ADDR_IRQ_MASK, 32'h1, OSF_RESP_OKAY);
      check({31'h0, irq}, 32'h0);
      // oscillator dies: interrupt and switch to the pll base clock
      osc_run <= 1'b0;
      repeat (300) @(posedge clk);
      check({31'h0, fallback}, 32'h1);
      check({31'h0, irq}, 32'h1);
      rd_exp(OSF_ADDR_STAT, 32'h3);
      rd_exp(OSF_ADDR_IRQ_STAT, 32'h1);
      measure(16'd80);
      axi_wr(OSF_ADDR_CTRL, 32'h2, OSF_RESP_OKAY);
      measure(16'd40);
      // oscillator back: source stays on the pll until reset
      osc_run <= 1'b1;
      axi_wr(OSF_ADDR_CTRL, 32'h0, OSF_RESP_OKAY);
      measure(16'd80);
      check({31'h0, fallback}, 32'h1);
      axi_wr(OSF_ADDR_IRQ_MASK, 32'h0, OSF_RESP_OKAY);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      axi_wr(OSF_ADDR_IRQ_MASK, 32'h1, OSF_RESP_OKAY);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      axi_wr(OSF_ADDR_IRQ_STAT, 32'h1, OSF_RESP_OKAY);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      rd_exp(OSF_ADDR_IRQ_STAT, 32'h0);
      // strap low at reset end: supervision off, pll idle
      do_reset(1'b0);
      check({31'h0, fallback}, 32'h0);
      rd_exp(OSF_ADDR_CTRL, 32'h1);
      rd_exp(OSF_ADDR_STAT, 32'h4);
      check({31'h0, pll_on}, 32'h0);
      measure(16'd100);
      axi_wr(OSF_ADDR_CTRL, 32'h3, OSF_RESP_OKAY);
      measure(16'd50);
      axi_wr(OSF_ADDR_IRQ_MASK, 32'h1, OSF_RESP_OKAY);
      osc_run <= 1'b0;
      repeat (300) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      check({31'h0, fallback}, 32'h0);
      rd_exp(OSF_ADDR_IRQ_STAT, 32'h0);
      osc_run <= 1'b1;
      close_out();
   end
endmodule // tb
`default_nettype wire
